// *** hw/fcs_alu.sv ***
`timescale 1ns/1ps
module fcs_alu (
  input  wire fcs_pkg::fcs_alu_op_t op,
  input  wire logic [7:0]           a,
  input  wire logic [7:0]           b,
  input  wire fcs_pkg::fcs_flags_t  flags_i,
  output logic      [7:0]           result,
  output fcs_pkg::fcs_flags_t       flags_o
);
  logic [7:0] bx;
  logic       ci;
  logic       arith;
  logic [8:0] sum;
  logic [4:0] half;

  always_comb
  begin
    bx    = b;
    ci    = 1'b0;
    arith = 1'b1;
    unique case (op)
      fcs_pkg::ALU_ADD: ci = 1'b0;
      fcs_pkg::ALU_ADC: ci = flags_i.c;
      fcs_pkg::ALU_SUB:
      begin
        bx = ~b;
        ci = 1'b1;
      end
      fcs_pkg::ALU_SBC:
      begin
        bx = ~b;
        ci = flags_i.c;
      end
      fcs_pkg::ALU_INC:
      begin
        bx = 8'h00;
        ci = 1'b1;
      end
      fcs_pkg::ALU_DEC: bx = 8'hff;
      default: arith = 1'b0;
    endcase
    sum  = {1'b0, a} + {1'b0, bx} + {8'h00, ci};
    half = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + {4'h0, ci};
    unique case (op)
      fcs_pkg::ALU_AND: result = a & b;
      fcs_pkg::ALU_OR:  result = a | b;
      fcs_pkg::ALU_XOR: result = a ^ b;
      fcs_pkg::ALU_CPL: result = ~a;
      default:          result = sum[7:0];
    endcase
    // carry is "no borrow" on subtraction; logic ops leave carry flags alone
    flags_o.c  = arith ? sum[8] : flags_i.c;
    flags_o.ac = arith ? half[4] : flags_i.ac;
    flags_o.ov = arith ? ((a[7] == bx[7]) && (sum[7] != a[7])) : flags_i.ov;
    flags_o.z  = (result == 8'h00);
  end
endmodule

// *** hw/fcs_fetch_seq.sv ***
`timescale 1ns/1ps
module fcs_fetch_seq (
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire logic                         ce,
  input  wire logic [fcs_pkg::AXI_AW-1:0]   s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready_q,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready_q,
  output logic [1:0]                        s_axi_bresp_q,
  output logic                              s_axi_bvalid_q,
  input  wire logic                         s_axi_bready,
  input  wire logic [fcs_pkg::AXI_AW-1:0]   s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready_q,
  output logic [31:0]                       s_axi_rdata_q,
  output logic [1:0]                        s_axi_rresp_q,
  output logic                              s_axi_rvalid_q,
  input  wire logic                         s_axi_rready,
  output logic [fcs_pkg::PC_W-1:0]          pmem_addr_q,
  input  wire logic [15:0]                  pmem_rdata,
  output fcs_pkg::fcs_phase_t               phase_q,
  output logic [15:0]                       instr_q,
  output logic                              instr_valid_q,
  output logic [fcs_pkg::PC_W-1:0]          instr_addr_q,
  input  wire fcs_pkg::fcs_cmd_t            cmd,
  input  wire logic                         irq_req,
  input  wire logic [fcs_pkg::PC_W-1:0]     irq_vector,
  output logic                              irq_ack_q,
  output logic                              dm_we_q,
  output logic [fcs_pkg::DM_AW-1:0]         dm_addr_q,
  output logic [7:0]                        dm_wdata_q,
  output fcs_pkg::fcs_flags_t               flags_q
);
  localparam int PC_W = fcs_pkg::PC_W;
  localparam int SP_W = $clog2(fcs_pkg::STACK_DEPTH);
  localparam int CN_W = SP_W + 1;
  localparam logic [CN_W-1:0] ST_FULL = CN_W'(fcs_pkg::STACK_DEPTH);

  logic [PC_W-1:0]          pc_q, fetch_addr_q, tab_addr_q, tab_addr_d, st_rdata;
  logic [15:0]              fetch_buf_q;
  logic                     tab_hold_q;
  logic [fcs_pkg::DM_AW-1:0] tab_dest_q, tab_dest_d;
  logic [SP_W-1:0]          st_ptr_q, st_raddr;
  logic [CN_W-1:0]          st_cnt_q;
  logic                     st_full, st_empty, push_p, pop_p;
  logic [7:0]               ctrl_q, tptr_lo_q, tptr_hi_q, tdh_q, pcl_val_q;
  logic                     pcl_pend_q, irq_pend_q;
  logic                     step, t4, pc_change, is_tab, irq_take, pcl_take, discard;
  fcs_pkg::fcs_op_t         op_eff;
  logic [7:0]               alu_res;
  fcs_pkg::fcs_flags_t      alu_flags;
  logic [fcs_pkg::AXI_AW-1:0] awaddr_q;
  logic [31:0]              wdata_q;
  logic [3:0]               wstrb_q;
  logic                     aw_have_q, w_have_q, wr_fire, wr_map;
  logic [7:0]               rd_val;
  logic                     rd_map;

  // run bit halts the sequencer while the register bus keeps working
  assign step      = ce & ctrl_q[fcs_pkg::CTRL_RUN];
  assign t4        = step && (phase_q == fcs_pkg::PH_T4);
  assign op_eff    = instr_valid_q ? cmd.op : fcs_pkg::OP_NONE;
  assign pc_change = op_eff inside {fcs_pkg::OP_JUMP, fcs_pkg::OP_CALL,
                                    fcs_pkg::OP_RET, fcs_pkg::OP_INTERRUPT_EXIT};
  assign is_tab    = op_eff inside {fcs_pkg::OP_TAB, fcs_pkg::OP_TABL,
                                    fcs_pkg::OP_TABX, fcs_pkg::OP_TABXL};
  // interrupts only at plain instruction boundaries, never with a full stack
  assign irq_take  = irq_pend_q && !st_full &&
                     (op_eff inside {fcs_pkg::OP_NONE, fcs_pkg::OP_ALU});
  assign pcl_take  = pcl_pend_q && !irq_take &&
                     (op_eff inside {fcs_pkg::OP_NONE, fcs_pkg::OP_ALU});
  assign discard   = pc_change | irq_take | pcl_take | is_tab |
                     (op_eff == fcs_pkg::OP_SKIP);
  assign push_p    = t4 && (irq_take || op_eff == fcs_pkg::OP_CALL);
  assign pop_p     = t4 && (op_eff inside {fcs_pkg::OP_RET, fcs_pkg::OP_INTERRUPT_EXIT});
  assign st_full   = (st_cnt_q == ST_FULL);
  assign st_empty  = (st_cnt_q == '0);
  assign st_raddr  = st_ptr_q - SP_W'(1);

  always_comb
  begin
    tab_dest_d = {2'b00, cmd.dest[7:0]};
    tab_addr_d = {tptr_hi_q[PC_W-9:0], tptr_lo_q};
    if (op_eff inside {fcs_pkg::OP_TABX, fcs_pkg::OP_TABXL})
    begin
      tab_dest_d = cmd.dest;
    end
    if (op_eff inside {fcs_pkg::OP_TABL, fcs_pkg::OP_TABXL})
    begin
      tab_addr_d = {{(PC_W-8){1'b1}}, tptr_lo_q};
    end
  end

  fcs_alu u_alu (
    .op      (cmd.alu_op),
    .a       (cmd.a),
    .b       (cmd.b),
    .flags_i (flags_q),
    .result  (alu_res),
    .flags_o (alu_flags)
  );

  fcs_stack_mem #(
    .DEPTH (fcs_pkg::STACK_DEPTH),
    .W     (PC_W),
    .AW    (SP_W)
  ) u_stack (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .we      (push_p),
    .waddr   (st_ptr_q),
    .wdata   (pc_q - PC_W'(1)),
    .raddr   (st_raddr),
    .rdata_q (st_rdata)
  );

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      phase_q <= fcs_pkg::PH_T1;
    end
    else if (step)
    begin
      unique case (phase_q)
        fcs_pkg::PH_T1: phase_q <= fcs_pkg::PH_T2;
        fcs_pkg::PH_T2: phase_q <= fcs_pkg::PH_T3;
        fcs_pkg::PH_T3: phase_q <= fcs_pkg::PH_T4;
        fcs_pkg::PH_T4: phase_q <= fcs_pkg::PH_T1;
        default:        phase_q <= fcs_pkg::PH_T1;
      endcase
    end
  end

  // fetch at T1, capture at T3, hand over and retire at T4
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pc_q          <= fcs_pkg::RESET_PC;
      pmem_addr_q   <= '0;
      fetch_addr_q  <= '0;
      fetch_buf_q   <= '0;
      instr_q       <= '0;
      instr_valid_q <= 1'b0;
      instr_addr_q  <= '0;
      tab_hold_q    <= 1'b0;
      tab_addr_q    <= '0;
      tab_dest_q    <= '0;
      irq_ack_q     <= 1'b0;
    end
    else if (step)
    begin
      irq_ack_q <= 1'b0;
      if (phase_q == fcs_pkg::PH_T1)
      begin
        if (tab_hold_q)
        begin
          pmem_addr_q <= tab_addr_q;
        end
        else
        begin
          pmem_addr_q  <= pc_q;
          fetch_addr_q <= pc_q;
          pc_q         <= pc_q + PC_W'(1);
        end
      end
      if (phase_q == fcs_pkg::PH_T3 && !tab_hold_q)
      begin
        fetch_buf_q <= pmem_rdata;
      end
      if (phase_q == fcs_pkg::PH_T4)
      begin
        // held prefetch survives the table cycle and issues afterwards
        instr_q       <= fetch_buf_q;
        instr_addr_q  <= fetch_addr_q;
        instr_valid_q <= !discard;
        tab_hold_q    <= is_tab;
        if (is_tab)
        begin
          tab_addr_q <= tab_addr_d;
          tab_dest_q <= tab_dest_d;
        end
        if (op_eff == fcs_pkg::OP_JUMP || op_eff == fcs_pkg::OP_CALL)
        begin
          pc_q <= cmd.target;
        end
        else if (pop_p)
        begin
          pc_q <= st_rdata;
        end
        else if (irq_take)
        begin
          pc_q      <= irq_vector;
          irq_ack_q <= 1'b1;
        end
        else if (pcl_take)
        begin
          pc_q <= {pc_q[PC_W-1:8], pcl_val_q};
        end
      end
    end
  end

  // circular stack: an overflowing push overwrites the oldest entry
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_ptr_q <= '0;
      st_cnt_q <= '0;
    end
    else if (push_p)
    begin
      st_ptr_q <= st_ptr_q + SP_W'(1);
      st_cnt_q <= st_full ? st_cnt_q : st_cnt_q + CN_W'(1);
    end
    else if (pop_p)
    begin
      st_ptr_q <= st_ptr_q - SP_W'(1);
      st_cnt_q <= st_empty ? st_cnt_q : st_cnt_q - CN_W'(1);
    end
  end

  // a fresh request in the acknowledge cycle stays pending
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_pend_q <= 1'b0;
    end
    else if (ce)
    begin
      irq_pend_q <= irq_req | (irq_pend_q & ~(t4 & irq_take));
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dm_we_q    <= 1'b0;
      dm_addr_q  <= '0;
      dm_wdata_q <= 8'h00;
      tdh_q      <= 8'h00;
      flags_q    <= '0;
    end
    else if (ce)
    begin
      dm_we_q <= 1'b0;
      if (wr_fire && wr_map && awaddr_q == fcs_pkg::REG_TDH && wstrb_q[0])
      begin
        tdh_q <= wdata_q[7:0];
      end
      if (step && phase_q == fcs_pkg::PH_T3 && tab_hold_q)
      begin
        dm_we_q    <= 1'b1;
        dm_addr_q  <= tab_dest_q;
        dm_wdata_q <= pmem_rdata[7:0];
        tdh_q      <= pmem_rdata[15:8];
      end
      else if (t4 && op_eff == fcs_pkg::OP_ALU)
      begin
        dm_we_q    <= 1'b1;
        dm_addr_q  <= cmd.dest;
        dm_wdata_q <= alu_res;
        flags_q    <= alu_flags;
      end
    end
  end

  assign wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid_q;
  assign wr_map  = awaddr_q inside {fcs_pkg::REG_PC_LOW, fcs_pkg::REG_TPTR_LO,
                   fcs_pkg::REG_TPTR_HI, fcs_pkg::REG_TDH, fcs_pkg::REG_STATUS,
                   fcs_pkg::REG_CTRL};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready_q <= 1'b1;
      s_axi_wready_q  <= 1'b1;
      s_axi_bvalid_q  <= 1'b0;
      s_axi_bresp_q   <= fcs_pkg::RESP_OKAY;
      aw_have_q       <= 1'b0;
      w_have_q        <= 1'b0;
      awaddr_q        <= '0;
      wdata_q         <= '0;
      wstrb_q         <= '0;
    end
    else if (ce)
    begin
      if (s_axi_bvalid_q && s_axi_bready)
      begin
        s_axi_bvalid_q  <= 1'b0;
        s_axi_awready_q <= 1'b1;
        s_axi_wready_q  <= 1'b1;
      end
      if (s_axi_awvalid && s_axi_awready_q)
      begin
        aw_have_q       <= 1'b1;
        awaddr_q        <= s_axi_awaddr;
        s_axi_awready_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready_q)
      begin
        w_have_q       <= 1'b1;
        wdata_q        <= s_axi_wdata;
        wstrb_q        <= s_axi_wstrb;
        s_axi_wready_q <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_have_q      <= 1'b0;
        w_have_q       <= 1'b0;
        s_axi_bvalid_q <= 1'b1;
        s_axi_bresp_q  <= wr_map ? fcs_pkg::RESP_OKAY : fcs_pkg::RESP_SLVERR;
      end
    end
  end

  // software registers; a bus write in the apply cycle re-arms the jump
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q     <= fcs_pkg::CTRL_RST;
      tptr_lo_q  <= 8'h00;
      tptr_hi_q  <= 8'h00;
      pcl_val_q  <= 8'h00;
      pcl_pend_q <= 1'b0;
    end
    else if (ce)
    begin
      if (t4 && pcl_take)
      begin
        pcl_pend_q <= 1'b0;
      end
      if (wr_fire && wstrb_q[0])
      begin
        unique case (awaddr_q)
          fcs_pkg::REG_PC_LOW:
          begin
            pcl_val_q  <= wdata_q[7:0];
            pcl_pend_q <= 1'b1;
          end
          fcs_pkg::REG_TPTR_LO: tptr_lo_q <= wdata_q[7:0];
          fcs_pkg::REG_TPTR_HI: tptr_hi_q <= {3'h0, wdata_q[PC_W-9:0]};
          fcs_pkg::REG_CTRL:    ctrl_q    <= {7'h00, wdata_q[fcs_pkg::CTRL_RUN]};
          default: ;
        endcase
      end
    end
  end

  // stack contents and pointer are deliberately absent from the map
  always_comb
  begin
    rd_map = 1'b1;
    case (s_axi_araddr)
      fcs_pkg::REG_PC_LOW:  rd_val = instr_addr_q[7:0];
      fcs_pkg::REG_TPTR_LO: rd_val = tptr_lo_q;
      fcs_pkg::REG_TPTR_HI: rd_val = tptr_hi_q;
      fcs_pkg::REG_TDH:     rd_val = tdh_q;
      fcs_pkg::REG_STATUS:  rd_val = {3'h0, irq_pend_q, flags_q};
      fcs_pkg::REG_CTRL:    rd_val = ctrl_q;
      default:
      begin
        rd_val = 8'h00;
        rd_map = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready_q <= 1'b1;
      s_axi_rvalid_q  <= 1'b0;
      s_axi_rdata_q   <= '0;
      s_axi_rresp_q   <= fcs_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_rvalid_q && s_axi_rready)
      begin
        s_axi_rvalid_q  <= 1'b0;
        s_axi_arready_q <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready_q)
      begin
        s_axi_arready_q <= 1'b0;
        s_axi_rvalid_q  <= 1'b1;
        s_axi_rdata_q   <= {24'h000000, rd_val};
        s_axi_rresp_q   <= rd_map ? fcs_pkg::RESP_OKAY : fcs_pkg::RESP_SLVERR;
      end
    end
  end

  phase_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (t4) |=> phase_q == fcs_pkg::PH_T1 ##1 (phase_q != fcs_pkg::PH_T3))
    else $error("phase sequence broken");
  pc_fetch_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (step && phase_q == fcs_pkg::PH_T1 && !tab_hold_q)
    |=> pc_q == $past(pc_q) + PC_W'(1) && pmem_addr_q == $past(pc_q))
    else $error("fetch did not use and advance counter");
  jump_dummy_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (t4 && op_eff == fcs_pkg::OP_JUMP) |=> !instr_valid_q && pc_q == $past(cmd.target))
    else $error("jump missed target or dummy cycle");
  skip_dummy_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (t4 && op_eff == fcs_pkg::OP_SKIP) |=> !instr_valid_q && pc_q == $past(pc_q))
    else $error("skip did not insert dummy cycle");
  page_jump_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (t4 && pcl_take) |=> pc_q[PC_W-1:8] == $past(pc_q[PC_W-1:8])
    && pc_q[7:0] == $past(pcl_val_q) && !instr_valid_q)
    else $error("low byte jump left page or kept prefetch");
  reset_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> pc_q == fcs_pkg::RESET_PC && st_empty)
    else $error("reset state wrong");
  full_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (t4 && irq_pend_q && st_full) |=> !irq_ack_q && irq_pend_q)
    else $error("interrupt acknowledged on full stack");
  call_push_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (push_p) |=> st_cnt_q == ($past(st_full) ? ST_FULL : $past(st_cnt_q) + CN_W'(1)))
    else $error("stack count wrong after push");
  tab_fetch_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (step && phase_q == fcs_pkg::PH_T1 && tab_hold_q)
    |=> pmem_addr_q == $past(tab_addr_q) && pc_q == $past(pc_q))
    else $error("table fetch address wrong");
  tab_high_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (step && phase_q == fcs_pkg::PH_T3 && tab_hold_q)
    |=> dm_we_q && tdh_q == $past(pmem_rdata[15:8]) && dm_wdata_q == $past(pmem_rdata[7:0]))
    else $error("table read data not delivered");
  alu_status_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (t4 && op_eff == fcs_pkg::OP_ALU) |=> dm_we_q && flags_q == $past(alu_flags))
    else $error("alu result or flags not stored");
endmodule

// *** hw/fcs_pkg.sv ***
package fcs_pkg;
  // largest variant; smaller parts simply leave the top address bits unused
  localparam int          PC_W        = 13;
  localparam int          STACK_DEPTH = 8;
  localparam int          DM_AW       = 10;
  localparam int          AXI_AW      = 8;
  localparam logic [12:0] RESET_PC    = 13'h0000;

  localparam logic [7:0] REG_PC_LOW  = 8'h00;
  localparam logic [7:0] REG_TPTR_LO = 8'h04;
  localparam logic [7:0] REG_TPTR_HI = 8'h08;
  localparam logic [7:0] REG_TDH     = 8'h0c;
  localparam logic [7:0] REG_STATUS  = 8'h10;
  localparam logic [7:0] REG_CTRL    = 8'h14;
  localparam logic [7:0] CTRL_RST    = 8'h01;
  localparam int         CTRL_RUN    = 0;
  localparam int         STAT_IRQ    = 4;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    PH_T1 = 4'h1,
    PH_T2 = 4'h2,
    PH_T3 = 4'h4,
    PH_T4 = 4'h8
  } fcs_phase_t;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_ALU  = 4'h1, OP_JUMP = 4'h2, OP_CALL = 4'h3,
    OP_RET  = 4'h4, OP_INTERRUPT_EXIT = 4'h5, OP_SKIP = 4'h6, OP_TAB  = 4'h7,
    OP_TABL = 4'h8, OP_TABX = 4'h9, OP_TABXL = 4'ha
  } fcs_op_t;

  typedef enum logic [3:0] {
    ALU_ADD = 4'h0, ALU_ADC = 4'h1, ALU_SUB = 4'h2, ALU_SBC = 4'h3,
    ALU_AND = 4'h4, ALU_OR  = 4'h5, ALU_XOR = 4'h6, ALU_INC = 4'h7,
    ALU_DEC = 4'h8, ALU_CPL = 4'h9
  } fcs_alu_op_t;

  // flag bit 0 is carry, 1 half carry, 2 zero, 3 overflow
  typedef struct packed {
    logic ov;
    logic z;
    logic ac;
    logic c;
  } fcs_flags_t;

  typedef struct packed {
    fcs_op_t           op;
    fcs_alu_op_t       alu_op;
    logic [PC_W-1:0]   target;
    logic [DM_AW-1:0]  dest;
    logic [7:0]        a;
    logic [7:0]        b;
  } fcs_cmd_t;
endpackage

// *** hw/fcs_stack_mem.sv ***
`timescale 1ns/1ps
module fcs_stack_mem #(
  parameter int DEPTH = fcs_pkg::STACK_DEPTH,
  parameter int W     = fcs_pkg::PC_W,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          ce,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata_q
);
  logic [W-1:0] mem [DEPTH];

  // storage has no reset; emptiness is tracked by the caller's count
  always_ff @(posedge aclk)
  begin
    if (ce && we)
    begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rdata_q <= '0;
    end
    else if (ce)
    begin
      rdata_q <= mem[raddr];
    end
  end
endmodule

// *** testbench/fcs_pmem_model.sv ***
`timescale 1ns/1ps
module fcs_pmem_model (
  input  wire logic [fcs_pkg::PC_W-1:0] addr,
  input  wire logic                     aclk,
  output logic      [15:0]              rdata_q
);
  // one-cycle registered read; contents are a fixed function of the address
  always_ff @(posedge aclk)
    rdata_q <= {3'h0, addr} ^ 16'ha5c3;
endmodule

// *** testbench/tb_cpu_fetch_sequencer.sv ***
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin n_errors++; \
  $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module tb_cpu_fetch_sequencer;
  logic                aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, irq_req = 1'b0;
  logic [7:0]          awaddr = '0, araddr = '0, dm_wdata;
  logic                awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
  logic [31:0]         wdata = '0, rdata, rd;
  logic [3:0]          wstrb = 4'hf, p;
  logic                awready, wready, bvalid, arready, rvalid, instr_valid, irq_ack, dm_we;
  logic [1:0]          bresp, rresp, rr;
  logic [12:0]         pmem_addr, instr_addr, a, irq_vector = '0;
  logic [15:0]         pmem_rdata, instr;
  logic [9:0]          dm_addr;
  fcs_pkg::fcs_phase_t phase;
  fcs_pkg::fcs_flags_t flags;
  fcs_pkg::fcs_cmd_t   cmd = '0;
  int                  n_errors = 0, comparisons = 0, i;
  always #2 aclk = ~aclk;
  fcs_fetch_seq DUT (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready_q(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready_q(wready),
    .s_axi_bresp_q(bresp), .s_axi_bvalid_q(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready_q(arready),
    .s_axi_rdata_q(rdata), .s_axi_rresp_q(rresp), .s_axi_rvalid_q(rvalid),
    .s_axi_rready(rready), .pmem_addr_q(pmem_addr), .pmem_rdata(pmem_rdata),
    .phase_q(phase), .instr_q(instr), .instr_valid_q(instr_valid),
    .instr_addr_q(instr_addr), .cmd(cmd), .irq_req(irq_req), .irq_vector(irq_vector),
    .irq_ack_q(irq_ack), .dm_we_q(dm_we), .dm_addr_q(dm_addr), .dm_wdata_q(dm_wdata),
    .flags_q(flags));
  fcs_pmem_model pmem (.aclk(aclk), .addr(pmem_addr), .rdata_q(pmem_rdata));
  task wrap_up;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task tmo;
    n_errors++;
    $display("CHECK FAILED wait exp done got timeout");
    wrap_up();
  endtask
  task axi_wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= ad; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (i = 0; i < 50 && bvalid !== 1'b1; i++)
    begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end
    if (i == 50) tmo();
    bready <= 1'b0;
    `CHK("bresp", fcs_pkg::RESP_OKAY, bresp)
  endtask
  task axi_rd(input logic [7:0] ad);
    @(posedge aclk);
    araddr <= ad; arvalid <= 1'b1; rready <= 1'b1;
    for (i = 0; i < 50 && rvalid !== 1'b1; i++)
    begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end
    if (i == 50) tmo();
    rd = rdata; rr = rresp; rready <= 1'b0;
  endtask
  task wait_ph(input fcs_pkg::fcs_phase_t ph);
    for (i = 0; i < 80; i++)
    begin
      @(negedge aclk);
      if (phase === ph && instr_valid === 1'b1) break;
    end
    if (i == 80) tmo();
  endtask
  // command is sampled at the edge ending phase four of a valid instruction
  task issue(input fcs_pkg::fcs_op_t o, input logic [12:0] t, input logic [9:0] d,
             input logic [7:0] x, input logic [7:0] y);
    wait_ph(fcs_pkg::PH_T3);
    @(posedge aclk);
    a = instr_addr;
    cmd <= '{o, fcs_pkg::ALU_ADD, t, d, x, y};
    @(posedge aclk);
    cmd <= '0;
  endtask
  task tab(input fcs_pkg::fcs_op_t o, input logic [9:0] ea, input logic [7:0] lo,
           input logic [7:0] hi);
    issue(o, '0, 10'h3a5, '0, '0);
    for (i = 0; i < 16 && dm_we !== 1'b1; i++)
      @(negedge aclk);
    `CHK("dm_addr", ea, dm_addr)
    `CHK("dm_wdata", lo, dm_wdata)
    axi_rd(fcs_pkg::REG_TDH);
    `CHK("tdh", {24'h0, hi}, rd)
  endtask
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    wait_ph(fcs_pkg::PH_T1);
    `CHK("reset pc", 13'h0000, instr_addr)
    for (int k = 0; k < 8; k++)
    begin
      p = phase;
      @(negedge aclk);
      `CHK("phase", {p[2:0], p[3]}, phase)
    end
    wait_ph(fcs_pkg::PH_T2);
    a = instr_addr;
    `CHK("prefetch", a + 13'h1, pmem_addr)
    wait_ph(fcs_pkg::PH_T4);
    wait_ph(fcs_pkg::PH_T1);
    `CHK("step", a + 13'h1, instr_addr)
    issue(fcs_pkg::OP_ALU, '0, 10'h011, 8'hff, 8'h01);
    @(negedge aclk);
    `CHK("alu", 11'h403, {dm_we, dm_wdata, flags.z, flags.c})
    issue(fcs_pkg::OP_JUMP, 13'h0123, '0, '0, '0);
    @(negedge aclk);
    `CHK("dummy", 1'b0, instr_valid)
    wait_ph(fcs_pkg::PH_T1);
    `CHK("jump", 13'h0123, instr_addr)
    axi_wr(fcs_pkg::REG_PC_LOW, 32'h40);
    for (int k = 0; k < 60 && !(instr_valid === 1'b1 && instr_addr[7:0] === 8'h40); k++)
      @(negedge aclk);
    `CHK("pcl jump", 13'h0140, instr_addr)
    issue(fcs_pkg::OP_CALL, 13'h0200, '0, '0, '0);
    wait_ph(fcs_pkg::PH_T1);
    `CHK("call", 13'h0200, instr_addr)
    p = a[3:0];
    issue(fcs_pkg::OP_RET, '0, '0, '0, '0);
    wait_ph(fcs_pkg::PH_T1);
    `CHK("ret", 13'h0140 + p + 13'h1, instr_addr)
    // one-cycle request pulse; pending flag must hold it until acknowledge
    @(posedge aclk);
    irq_vector <= 13'h0300;
    irq_req    <= 1'b1;
    @(posedge aclk);
    irq_req <= 1'b0;
    for (i = 0; i < 40 && irq_ack !== 1'b1; i++)
      @(negedge aclk);
    `CHK("irq ack", 1'b1, irq_ack)
    wait_ph(fcs_pkg::PH_T1);
    `CHK("irq vector", 13'h0300, instr_addr)
    `CHK("irq instr", 16'ha6c3, instr)
    axi_wr(fcs_pkg::REG_TPTR_LO, 32'h06);
    axi_wr(fcs_pkg::REG_TPTR_HI, 32'h07);
    tab(fcs_pkg::OP_TAB, 10'h0a5, 8'hc5, 8'ha2);
    tab(fcs_pkg::OP_TABXL, 10'h3a5, 8'hc5, 8'hba);
    axi_rd(8'h18);
    `CHK("unmapped", 2'h2, rr)
    wrap_up();
  end
endmodule
